// file: cpu_status_ctrl.sv
// Processor flags, mode bits, condition evaluation, interrupt entry and trap
`timescale 1ns/1ps
`default_nettype none

module cpu_status_ctrl (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire cpu_status_pkg::exec_req_t exec,
    input wire cpu_status_pkg::flag_upd_t flag_upd,
    input wire cpu_status_pkg::cond_req_t cond,
    output logic cond_valid,
    output logic cond_taken,
    output logic [5:0] flags,
    output logic long_word_mode,
    output logic eff_long_word,
    output logic master_irq_enable,
    output logic [1:0] irq_mode_field,
    output logic bus_lock_bit,
    output logic alt_acc_flags_select,
    input wire logic busreq_n,
    output logic busack_n,
    input wire logic irq0_n,
    input wire logic insn_end,
    input wire logic iter_end,
    input wire logic block_active,
    input wire logic [31:0] insn_addr,
    input wire logic [31:0] next_addr,
    output logic irq_ack,
    output logic block_suspend,
    output logic [31:0] push_addr,
    input wire logic ack_done,
    input wire logic vec_undefined,
    input wire logic undef_opcode,
    output logic trap_take,
    output logic [31:0] jump_addr,
    output logic [1:0] trap_status
);

    // ****************************************
    // Declarations
    // ****************************************
    typedef enum logic [0:0] {
        ST_RUN = 1'b0,
        ST_ACK = 1'b1
    } entry_state_t;

    entry_state_t state;
    logic [5:0] flags_pri;
    logic [5:0] flags_alt;
    logic [5:0] next_flags_pri;
    logic [5:0] next_flags_alt;
    logic [5:0] fwd_flags;
    logic decoder_directive_prefix_active;
    logic decoder_directive_prefix_long;
    logic req_level_n;
    logic irq_level_n;
    logic eval_taken;
    logic boundary;
    logic take_irq;
    logic suspend_now;
    logic vec_trap;
    logic mode_wr;
    logic trap_wr;

    // ****************************************
    // Input synchronisers and condition check
    // ****************************************
    pin_sync u_busreq_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .pin(busreq_n),
        .level(req_level_n)
    );
    pin_sync u_irq_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .pin(irq0_n),
        .level(irq_level_n)
    );
    cond_eval u_cond (
        .flags(fwd_flags),
        .code(cond.code),
        .relative(cond.relative),
        .taken(eval_taken)
    );

    // ****************************************
    // Flag banks
    // ****************************************
    always_comb
    begin
        next_flags_pri = flags_pri;
        next_flags_alt = flags_alt;
        for (int i = 0; i < cpu_status_pkg::FLAG_WIDTH; i++)
        begin
            if (flag_upd.we[i] && !alt_acc_flags_select)
                next_flags_pri[i] = flag_upd.value[i];
            if (flag_upd.we[i] && alt_acc_flags_select)
                next_flags_alt[i] = flag_upd.value[i];
        end
    end
    // Forwarding lets a conditional follow a flag writer back to back
    assign fwd_flags = alt_acc_flags_select ? next_flags_alt : next_flags_pri;
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            flags_pri <= cpu_status_pkg::FLAGS_RESET;
            flags_alt <= cpu_status_pkg::FLAGS_RESET;
        end
        else
        begin
            flags_pri <= next_flags_pri;
            flags_alt <= next_flags_alt;
        end
    end
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            flags <= cpu_status_pkg::FLAGS_RESET;
        else if (exec.op == cpu_status_pkg::OP_EX_AF)
            flags <= alt_acc_flags_select ? next_flags_pri : next_flags_alt;
        else
            flags <= fwd_flags;
    end
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cond_valid <= 1'b0;
            cond_taken <= 1'b0;
        end
        else
        begin
            cond_valid <= cond.valid;
            cond_taken <= cond.valid & eval_taken;
        end
    end

    // ****************************************
    // Mode bits
    // ****************************************
    assign mode_wr = reg_wr && (reg_addr == cpu_status_pkg::ADDR_MODE);
    assign trap_wr = reg_wr && (reg_addr == cpu_status_pkg::ADDR_TRAP);

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            long_word_mode <= 1'b0;
        else if (exec.op == cpu_status_pkg::OP_SET_CTL && exec.arg == cpu_status_pkg::CTL_LW)
            long_word_mode <= 1'b1;
        else if (exec.op == cpu_status_pkg::OP_CLR_CTL && exec.arg == cpu_status_pkg::CTL_LW)
            long_word_mode <= 1'b0;
        else if (mode_wr)
            long_word_mode <= reg_wdata[cpu_status_pkg::MODE_LW_BIT];
    end
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            bus_lock_bit <= 1'b0;
        else if (exec.op == cpu_status_pkg::OP_SET_CTL && exec.arg == cpu_status_pkg::CTL_LOCK)
            bus_lock_bit <= 1'b1;
        else if (exec.op == cpu_status_pkg::OP_CLR_CTL && exec.arg == cpu_status_pkg::CTL_LOCK)
            bus_lock_bit <= 1'b0;
        else if (mode_wr)
            bus_lock_bit <= reg_wdata[cpu_status_pkg::MODE_LOCK_BIT];
    end
    // Acknowledge beats an enable in the same cycle so nesting stays closed
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            master_irq_enable <= 1'b0;
        else if (take_irq || exec.op == cpu_status_pkg::OP_DI)
            master_irq_enable <= 1'b0;
        else if (exec.op == cpu_status_pkg::OP_EI)
            master_irq_enable <= 1'b1;
        else if (mode_wr)
            master_irq_enable <= reg_wdata[cpu_status_pkg::MODE_IE_BIT];
    end
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            irq_mode_field <= cpu_status_pkg::IM_RESET;
        else if (exec.op == cpu_status_pkg::OP_IM)
            irq_mode_field <= exec.arg;
        else if (mode_wr)
            irq_mode_field <= reg_wdata[cpu_status_pkg::MODE_IM_LSB +: 2];
    end
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            alt_acc_flags_select <= 1'b0;
        else if (exec.op == cpu_status_pkg::OP_EX_AF)
            alt_acc_flags_select <= ~alt_acc_flags_select;
        else if (mode_wr)
            alt_acc_flags_select <= reg_wdata[cpu_status_pkg::MODE_ALT_BIT];
    end

    // ****************************************
    // Size directive
    // ****************************************
    // One directive covers exactly one instruction; the prefix gives no end pulse
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            decoder_directive_prefix_active <= 1'b0;
            decoder_directive_prefix_long <= 1'b0;
        end
        else if (exec.op == cpu_status_pkg::OP_DECODER_DIRECTIVE_PREFIX && exec.arg != 2'h0)
        begin
            decoder_directive_prefix_active <= 1'b1;
            decoder_directive_prefix_long <= (exec.arg == cpu_status_pkg::DECODER_DIRECTIVE_PREFIX_LONG);
        end
        else if (insn_end)
            decoder_directive_prefix_active <= 1'b0;
    end
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            eff_long_word <= 1'b0;
        else if (exec.op == cpu_status_pkg::OP_DECODER_DIRECTIVE_PREFIX && exec.arg != 2'h0)
            eff_long_word <= (exec.arg == cpu_status_pkg::DECODER_DIRECTIVE_PREFIX_LONG);
        else if (decoder_directive_prefix_active && !insn_end)
            eff_long_word <= decoder_directive_prefix_long;
        else
            eff_long_word <= long_word_mode;
    end

    // ****************************************
    // Bus request arbitration
    // ****************************************
    // A grant already given is not withdrawn by a later lock
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            busack_n <= 1'b1;
        else
            busack_n <= ~(~req_level_n & (~busack_n | ~bus_lock_bit));
    end

    // ****************************************
    // Interrupt entry
    // ****************************************
    assign boundary = insn_end || (block_active && iter_end);
    assign take_irq = (state == ST_RUN) && boundary && !irq_level_n && master_irq_enable;
    assign suspend_now = take_irq && block_active && !insn_end;
    assign vec_trap = (state == ST_ACK) && ack_done && vec_undefined &&
        (irq_mode_field == cpu_status_pkg::IM_MODE0);
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            state <= ST_RUN;
        else
        begin
            case (state)
                ST_RUN:
                    if (take_irq)
                        state <= ST_ACK;
                ST_ACK:
                    if (ack_done)
                        state <= ST_RUN;
                default: state <= ST_RUN;
            endcase
        end
    end
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            irq_ack <= 1'b0;
            block_suspend <= 1'b0;
            push_addr <= 32'h00000000;
        end
        else
        begin
            irq_ack <= take_irq;
            // Suspension waits for the iteration end, when counters are settled
            block_suspend <= suspend_now;
            if (take_irq)
                push_addr <= suspend_now ? insn_addr : next_addr;
        end
    end

    // ****************************************
    // Undefined opcode trap
    // ****************************************
    // No enable term exists here on purpose: the trap cannot be masked
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            trap_take <= 1'b0;
            jump_addr <= cpu_status_pkg::TRAP_ADDR;
        end
        else
        begin
            trap_take <= undef_opcode | vec_trap;
            jump_addr <= cpu_status_pkg::TRAP_ADDR;
        end
    end
    // Write one clears; a trap in the same cycle keeps its bit set
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            trap_status <= cpu_status_pkg::TRAP_RESET;
        else
        begin
            if (trap_wr)
                trap_status <= trap_status & ~reg_wdata[1:0];
            if (undef_opcode)
                trap_status[cpu_status_pkg::TRAP_FETCH_BIT] <= 1'b1;
            if (vec_trap)
                trap_status[cpu_status_pkg::TRAP_VECTOR_BIT] <= 1'b1;
        end
    end

    // ****************************************
    // Register read port
    // ****************************************
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            reg_rdata <= 32'h00000000;
        else if (!reg_rd)
            reg_rdata <= 32'h00000000;
        else if (reg_addr == cpu_status_pkg::ADDR_MODE)
            reg_rdata <= {26'h0000000, alt_acc_flags_select, bus_lock_bit,
                irq_mode_field, master_irq_enable, long_word_mode};
        else if (reg_addr == cpu_status_pkg::ADDR_FLAGS)
            reg_rdata <= {18'h00000, flags_alt, 2'h0, flags_pri};
        else if (reg_addr == cpu_status_pkg::ADDR_TRAP)
            reg_rdata <= {30'h00000000, trap_status};
        else
            reg_rdata <= 32'h00000000;
    end

endmodule

`default_nettype wire

// file: cpu_status_pkg.sv
// Shared constants and types for the processor status and exception logic
package cpu_status_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_FLAGS = 8'h04;
    localparam logic [7:0] ADDR_TRAP = 8'h08;

    localparam int MODE_LW_BIT = 0;
    localparam int MODE_IE_BIT = 1;
    localparam int MODE_IM_LSB = 2;
    localparam int MODE_LOCK_BIT = 4;
    localparam int MODE_ALT_BIT = 5;
    localparam int MODE_WIDTH = 6;
    localparam logic [5:0] MODE_RESET = 6'h00;

    // Flag positions inside the six-bit flag word
    localparam int FLAG_C = 0;
    localparam int FLAG_N = 1;
    localparam int FLAG_PV = 2;
    localparam int FLAG_H = 3;
    localparam int FLAG_Z = 4;
    localparam int FLAG_S = 5;
    localparam int FLAG_WIDTH = 6;
    localparam logic [5:0] FLAGS_RESET = 6'h00;
    localparam int FLAGS_ALT_LSB = 8;

    localparam int TRAP_FETCH_BIT = 0;
    localparam int TRAP_VECTOR_BIT = 1;
    localparam logic [1:0] TRAP_RESET = 2'h0;
    localparam logic [31:0] TRAP_ADDR = 32'h00000000;
    localparam logic [1:0] IM_RESET = 2'h0;
    localparam logic [1:0] IM_MODE0 = 2'h0;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_SET_CTL = 3'b001,
        OP_CLR_CTL = 3'b010,
        OP_EI = 3'b011,
        OP_DI = 3'b100,
        OP_IM = 3'b101,
        OP_EX_AF = 3'b110,
        OP_DECODER_DIRECTIVE_PREFIX = 3'b111
    } ctl_op_t;

    localparam logic [1:0] CTL_LW = 2'h0;
    localparam logic [1:0] CTL_LOCK = 2'h1;
    localparam logic [1:0] DECODER_DIRECTIVE_PREFIX_WORD = 2'h1;
    localparam logic [1:0] DECODER_DIRECTIVE_PREFIX_LONG = 2'h2;

    typedef struct packed {
        ctl_op_t op;
        logic [1:0] arg;
    } exec_req_t;

    typedef struct packed {
        logic [5:0] we;
        logic [5:0] value;
    } flag_upd_t;

    typedef struct packed {
        logic valid;
        logic relative;
        logic [2:0] code;
    } cond_req_t;

endpackage

// file: pin_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic pin,
    output logic level
);

    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s1 <= RST_VAL;
            s2 <= RST_VAL;
            s3 <= RST_VAL;
        end
        else
        begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Filters a single-cycle glitch, which passes stage three but never sits in stages two and three together
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            level <= RST_VAL;
        else if (s2 == s3)
            level <= s3;
    end

endmodule

`default_nettype wire

// file: cond_eval.sv
// Combinational evaluation of a three-bit condition code against the flags
`timescale 1ns/1ps
`default_nettype none

module cond_eval (
    input wire logic [5:0] flags,
    input wire logic [2:0] code,
    input wire logic relative,
    output logic taken
);

    logic sel;

    always_comb
    begin
        sel = 1'b0;
        if (relative)
        begin
            // Relative forms only know four codes; the low half never holds
            case (code)
                3'b100: sel = ~flags[cpu_status_pkg::FLAG_Z];
                3'b101: sel = flags[cpu_status_pkg::FLAG_Z];
                3'b110: sel = ~flags[cpu_status_pkg::FLAG_C];
                3'b111: sel = flags[cpu_status_pkg::FLAG_C];
                default: sel = 1'b0;
            endcase
        end
        else
        begin
            case (code[2:1])
                2'b00: sel = flags[cpu_status_pkg::FLAG_Z];
                2'b01: sel = flags[cpu_status_pkg::FLAG_C];
                2'b10: sel = flags[cpu_status_pkg::FLAG_PV];
                default: sel = flags[cpu_status_pkg::FLAG_S];
            endcase
            sel = sel ~^ code[0];
        end
        taken = sel;
    end

endmodule

`default_nettype wire

// file: cpu_status_ctrl_sva.sv
// Port-level assertions for the status and exception block
`timescale 1ns/1ps
`default_nettype none
module cpu_status_ctrl_sva (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire cpu_status_pkg::exec_req_t exec,
    input wire cpu_status_pkg::cond_req_t cond,
    input wire logic cond_valid,
    input wire logic cond_taken,
    input wire logic [5:0] flags,
    input wire logic long_word_mode,
    input wire logic master_irq_enable,
    input wire logic [1:0] irq_mode_field,
    input wire logic bus_lock_bit,
    input wire logic alt_acc_flags_select,
    input wire logic busack_n,
    input wire logic [31:0] insn_addr,
    input wire logic irq_ack,
    input wire logic block_suspend,
    input wire logic [31:0] push_addr,
    input wire logic undef_opcode,
    input wire logic trap_take,
    input wire logic [31:0] jump_addr,
    input wire logic [1:0] trap_status
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    // Relative forms test Z or C only, top code bit set
    function automatic logic cond_ok(input logic [5:0] f, input logic [2:0] c, input logic r);
        logic [1:0] s;
        s = r ? {1'b0, c[1]} : c[2:1];
        case (s)
            2'h0: return (!r || c[2]) && f[cpu_status_pkg::FLAG_Z] == c[0];
            2'h1: return (!r || c[2]) && f[cpu_status_pkg::FLAG_C] == c[0];
            2'h2: return f[cpu_status_pkg::FLAG_PV] == c[0];
            default: return f[cpu_status_pkg::FLAG_S] == c[0];
        endcase
    endfunction

    cond_pipe_a: assert property (cond.valid |=> cond_valid)
        else $error("condition answer missing");
    // A bank swap changes the visible flags, so those cycles are left out
    cond_eval_a: assert property (
        cond_valid && $past(exec.op) != cpu_status_pkg::OP_EX_AF
        |-> cond_taken == cond_ok(flags, $past(cond.code), $past(cond.relative)))
        else $error("condition result wrong");
    lw_ctl_a: assert property (
        exec.op inside {cpu_status_pkg::OP_SET_CTL, cpu_status_pkg::OP_CLR_CTL}
        && exec.arg == cpu_status_pkg::CTL_LW
        |=> long_word_mode == ($past(exec.op) == cpu_status_pkg::OP_SET_CTL))
        else $error("long word bit wrong");
    im_write_a: assert property (
        exec.op == cpu_status_pkg::OP_IM |=> irq_mode_field == $past(exec.arg))
        else $error("irq mode not written");
    bank_swap_a: assert property (
        exec.op == cpu_status_pkg::OP_EX_AF
        |=> alt_acc_flags_select != $past(alt_acc_flags_select))
        else $error("bank select not toggled");
    irq_gate_a: assert property (
        irq_ack |-> $past(master_irq_enable) && !master_irq_enable)
        else $error("irq enable misused");
    suspend_addr_a: assert property (
        irq_ack && block_suspend |-> push_addr == $past(insn_addr))
        else $error("suspend address wrong");
    lock_hold_a: assert property (
        bus_lock_bit && busack_n && exec.op == cpu_status_pkg::OP_NONE |=> busack_n)
        else $error("grant while locked");
    trap_take_a: assert property (
        undef_opcode |=> trap_take && trap_status[0] && jump_addr == cpu_status_pkg::TRAP_ADDR)
        else $error("trap not taken");

    cover property (irq_ack && block_suspend);
    cover property (trap_take && trap_status[1]);
    cover property (cond_valid && cond_taken);
endmodule
bind cpu_status_ctrl cpu_status_ctrl_sva chk (.*);
`default_nettype wire

// file: irq_bus_partner.sv
// Far-side model: interrupting peripheral and bus requester
`timescale 1ns/1ps
`default_nettype none
module irq_bus_partner (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic irq_on,
    input wire logic bus_on,
    input wire logic bad_vec,
    input wire logic [3:0] lat,
    input wire logic irq_ack,
    output logic irq0_n,
    output logic busreq_n,
    output var logic ack_done,
    output logic vec_undefined
);
    logic [3:0] cnt;
    // Request pins rest high, as their pull-ups leave them
    assign irq0_n = ~irq_on;
    assign busreq_n = ~bus_on;
    // Outside the acknowledge strobe the vector flag carries nothing useful
    assign vec_undefined = ack_done ? bad_vec : ~bad_vec;
    always_ff @(posedge ref_clk or negedge rstn)
        if (!rstn)
        begin
            cnt <= 4'h0;
            ack_done <= 1'b0;
        end
        else
        begin
            ack_done <= cnt == 4'h1;
            if (irq_ack)
                cnt <= lat;
            else if (cnt != 4'h0)
                cnt <= cnt - 4'h1;
        end
endmodule
`default_nettype wire

// file: tb.sv
// Self-checking bench for the status and exception block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, insn_addr = 32'h0, next_addr = 32'h0;
    logic [31:0] reg_rdata, push_addr, jump_addr, rd;
    cpu_status_pkg::exec_req_t exec = '0;
    cpu_status_pkg::flag_upd_t flag_upd = '0;
    cpu_status_pkg::cond_req_t cond = '0;
    logic insn_end = 1'b0, iter_end = 1'b0, block_active = 1'b0, undef_opcode = 1'b0;
    logic irq_on = 1'b0, bus_on = 1'b0, bad_vec = 1'b0;
    logic [3:0] lat = 4'h9;
    logic [5:0] flags, f;
    logic [1:0] irq_mode_field, trap_status;
    logic cond_valid, cond_taken, long_word_mode, eff_long_word, master_irq_enable;
    logic bus_lock_bit, alt_acc_flags_select, busack_n, irq_ack, block_suspend, trap_take;
    logic irq0_n, busreq_n, ack_done, vec_undefined;
    int error_cnt = 0, n_checks = 0, m_lw = 0, m_ie = 0, m_im = 0, m_lock = 0, m_alt = 0;
    int sel [4] = '{cpu_status_pkg::FLAG_Z, cpu_status_pkg::FLAG_C, cpu_status_pkg::FLAG_PV,
        cpu_status_pkg::FLAG_S};
    bit q_exp [$];

    cpu_status_ctrl uut (.*);
    irq_bus_partner peer (.*);

    initial
        forever #4 ref_clk = ~ref_clk;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("Comparisons %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wait_lvl(ref logic s, input logic v);
        int n = 0;
        while (s !== v)
        begin
            @(negedge ref_clk);
            n++;
            if (n > 50)
            begin
                chk(s, v, "wait timeout");
                end_sim();
            end
        end
    endtask

    task automatic rd_reg(input logic [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        rd = reg_rdata;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic step(input logic e, input logic it, input logic u);
        @(posedge ref_clk);
        {insn_end, iter_end, block_active, undef_opcode} <= {e, it, it, u};
        @(posedge ref_clk);
        {insn_end, iter_end, block_active, undef_opcode} <= 4'h0;
        @(negedge ref_clk);
    endtask

    // One control op, then port and register checks
    task automatic do_op(input cpu_status_pkg::ctl_op_t o, input logic [1:0] a);
        logic [5:0] e;
        @(posedge ref_clk);
        exec <= '{o, a};
        @(posedge ref_clk);
        exec <= '0;
        case (o)
            cpu_status_pkg::OP_SET_CTL, cpu_status_pkg::OP_CLR_CTL:
                if (a == cpu_status_pkg::CTL_LW)
                    m_lw = o == cpu_status_pkg::OP_SET_CTL;
                else
                    m_lock = o == cpu_status_pkg::OP_SET_CTL;
            cpu_status_pkg::OP_EI: m_ie = 1;
            cpu_status_pkg::OP_DI: m_ie = 0;
            cpu_status_pkg::OP_IM: m_im = a;
            cpu_status_pkg::OP_EX_AF: m_alt = 1 - m_alt;
            default: ;
        endcase
        e = {1'(m_alt), 1'(m_lock), 2'(m_im), 1'(m_ie), 1'(m_lw)};
        @(negedge ref_clk);
        chk({alt_acc_flags_select, bus_lock_bit, irq_mode_field, master_irq_enable,
            long_word_mode}, e, "mode bits");
        rd_reg(cpu_status_pkg::ADDR_MODE);
        chk(rd, e, "mode reg");
    endtask

    always @(negedge ref_clk)
        if (cond_valid === 1'b1)
            chk(cond_taken, q_exp.pop_front(), "condition");

    initial
    begin
        void'($urandom(48));
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        step(1'b0, 1'b0, 1'b1);
        chk({trap_take, trap_status}, 3'h5, "fetch trap");
        chk(jump_addr, cpu_status_pkg::TRAP_ADDR, "trap target");
        wr_reg(cpu_status_pkg::ADDR_TRAP, 32'h1);
        rd_reg(cpu_status_pkg::ADDR_TRAP);
        chk(rd, 32'h0, "trap cleared");
        wr_reg(8'h0C, 32'hFFFFFFFF);
        rd_reg(8'h0C);
        chk(rd, 32'h0, "unmapped");
        wr_reg(cpu_status_pkg::ADDR_MODE, 32'h3F);
        rd_reg(cpu_status_pkg::ADDR_MODE);
        chk(rd, 32'h3F, "mode write");
        wr_reg(cpu_status_pkg::ADDR_MODE, 32'h0);
        $display("Test trap done");
        do_op(cpu_status_pkg::OP_SET_CTL, cpu_status_pkg::CTL_LW);
        do_op(cpu_status_pkg::OP_DECODER_DIRECTIVE_PREFIX, cpu_status_pkg::DECODER_DIRECTIVE_PREFIX_WORD);
        chk(eff_long_word, 1'b0, "word prefix");
        step(1'b1, 1'b0, 1'b0);
        chk(eff_long_word, 1'b1, "mode size");
        do_op(cpu_status_pkg::OP_CLR_CTL, cpu_status_pkg::CTL_LW);
        do_op(cpu_status_pkg::OP_DECODER_DIRECTIVE_PREFIX, cpu_status_pkg::DECODER_DIRECTIVE_PREFIX_LONG);
        chk(eff_long_word, 1'b1, "long prefix");
        step(1'b1, 1'b0, 1'b0);
        chk(eff_long_word, 1'b0, "prefix over");
        for (int m = 3; m >= 0; m--)
            do_op(cpu_status_pkg::OP_IM, 2'(m));
        do_op(cpu_status_pkg::OP_EI, 2'h0);
        do_op(cpu_status_pkg::OP_DI, 2'h0);
        $display("Test mode done");
        // Back-to-back requests, each on its own flag update
        for (int i = 0; i < 32; i++)
        begin
            @(posedge ref_clk);
            f = 6'($urandom);
            flag_upd <= '{6'h3F, f};
            cond <= '{1'b1, i[3], i[2:0]};
            q_exp.push_back(i[3] ? (i[2] && f[sel[i[1]]] == i[0]) : f[sel[i[2:1]]] == i[0]);
        end
        @(posedge ref_clk);
        flag_upd <= '0;
        cond <= '0;
        repeat (2) @(negedge ref_clk);
        chk(q_exp.size(), 0, "all answered");
        chk(flags, f, "flags");
        do_op(cpu_status_pkg::OP_EX_AF, 2'h0);
        chk(flags, 6'h00, "alt bank");
        @(posedge ref_clk);
        flag_upd <= '{6'h3F, 6'h2A};
        @(posedge ref_clk);
        flag_upd <= '0;
        rd_reg(cpu_status_pkg::ADDR_FLAGS);
        chk(rd, {18'h0, 6'h2A, 2'h0, f}, "flag banks");
        do_op(cpu_status_pkg::OP_EX_AF, 2'h0);
        chk(flags, f, "primary back");
        $display("Test condition done");
        do_op(cpu_status_pkg::OP_SET_CTL, cpu_status_pkg::CTL_LOCK);
        @(posedge ref_clk);
        bus_on <= 1'b1;
        repeat (10) @(negedge ref_clk);
        chk(busack_n, 1'b1, "locked bus");
        do_op(cpu_status_pkg::OP_CLR_CTL, cpu_status_pkg::CTL_LOCK);
        wait_lvl(busack_n, 1'b0);
        @(posedge ref_clk);
        bus_on <= 1'b0;
        wait_lvl(busack_n, 1'b1);
        $display("Test lock done");
        @(posedge ref_clk);
        irq_on <= 1'b1;
        insn_addr <= $urandom;
        next_addr <= $urandom;
        repeat (6) @(posedge ref_clk);
        step(1'b1, 1'b0, 1'b0);
        chk(irq_ack, 1'b0, "masked irq");
        do_op(cpu_status_pkg::OP_EI, 2'h0);
        step(1'b0, 1'b1, 1'b0);
        m_ie = 0;
        chk({irq_ack, block_suspend, master_irq_enable}, 3'h6, "block cut");
        chk(push_addr, insn_addr, "own address");
        @(posedge ref_clk);
        irq_on <= 1'b0;
        lat <= 4'h1;
        wait_lvl(ack_done, 1'b1);
        do_op(cpu_status_pkg::OP_EI, 2'h0);
        @(posedge ref_clk);
        irq_on <= 1'b1;
        bad_vec <= 1'b1;
        repeat (6) @(posedge ref_clk);
        step(1'b1, 1'b0, 1'b0);
        m_ie = 0;
        chk({irq_ack, block_suspend}, 2'h2, "boundary irq");
        chk(push_addr, next_addr, "next address");
        wait_lvl(trap_take, 1'b1);
        chk(trap_status, 2'h2, "vector trap");
        $display("Test interrupt done");
        end_sim();
    end
endmodule
`default_nettype wire
